// ==== rtl/rsm_top.sv ====
//Function
// [RULE_01] Pulse stomped indicator on inverted FCS frames
// [RULE_02] Truncate overlong frames, pulse truncation flag
// [RULE_03] Internal fault while test, misaligned, high BER
// [RULE_04] Received fault from partner fault machine
// [RULE_05] Per-lane one-cycle BIP8 error pulses
// [RULE_06] High error rate level mirrors PCS
// [RULE_07] Preamble output valid on frame start
// [RULE_08] Four-bit gap setting targets average gap
// [RULE_09] Settings 0-7 give terminate-only gap
// [RULE_10] Flag received Signal ordered-set words
// [RULE_11] Fault code processing on/off control
// [RULE_12] Receive test mode checks scrambled idle
// [RULE_13] Transmit test mode generates scrambled idle
// [RULE_14] Mismatch count pulse each checking cycle
// [RULE_15] Aligned status only when all lanes deskewed
// [RULE_16] Mismatch output zero when checking off
`timescale 1ns/1ps
`include "rsm_cfg.svh"

module rsm_top #(
  parameter int VL_LANES = `RSM_VL_LANES,
  parameter int MISM_W = `RSM_MISM_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Receive frame events from the decoder
  input wire logic rx_frame_end,
  input wire logic rx_fcs_inverted,
  input wire logic rx_frame_active,
  input wire logic rx_byte_inc_vld,
  input wire logic [4:0] rx_byte_inc,
  input wire logic rx_sof,
  input wire logic [`RSM_PRE_W-1:0] rx_preamble,
  // Receive PCS indications
  input wire logic rx_word_vld,
  input wire logic rx_lf_word,
  input wire logic rx_signal_os_word,
  input wire logic [VL_LANES-1:0] lane_bip_bad,
  input wire logic [VL_LANES-1:0] lane_deskewed,
  input wire logic ber_over_threshold,
  input wire logic [MISM_W-1:0] rx_pattern_errs,
  // Controls
  input wire logic [`RSM_MAX_LEN_W-1:0] max_frame_len,
  input wire logic custom_preamble_enable,
  input wire logic process_local_fault,
  input wire logic rx_test_pattern,
  input wire logic tx_test_pattern,
  input wire logic [`RSM_IPG_W-1:0] tx_ipg_value,
  // Status outputs
  output logic stomped_fcs,
  output logic truncated,
  output logic rx_drop_frame,
  output logic internal_local_fault,
  output logic received_local_fault,
  output logic [VL_LANES-1:0] bip_err,
  output logic high_error_rate,
  output logic lanes_aligned,
  output logic signal_set_seen,
  output logic [`RSM_PRE_W-1:0] preamble_out,
  output logic [MISM_W-1:0] test_pattern_mismatch,
  // Transmit controls and receive idle check
  output logic tx_send_idles,
  output logic [`RSM_IPG_W-1:0] tx_gap_bytes,
  output logic tx_scrambled_idle,
  output logic rx_check_idle
);
  // ----------------------------------------
  // Frame status
  // ----------------------------------------
  logic [15:0] len_r;
  logic trunc_done_r;
  logic [15:0] len_sum;

  assign len_sum = len_r + {11'h0, rx_byte_inc};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stomped_fcs <= 1'b0;
    end else begin
      stomped_fcs <= rx_frame_end && rx_fcs_inverted; // see [RULE_01]
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      len_r <= 16'h0;
      trunc_done_r <= 1'b0;
      truncated <= 1'b0;
    end else begin
      truncated <= 1'b0;
      if (!rx_frame_active) begin
        len_r <= 16'h0;
        trunc_done_r <= 1'b0;
      end else if (rx_byte_inc_vld) begin
        len_r <= len_sum;
        if (!trunc_done_r && len_sum > {1'b0, max_frame_len}) begin
          truncated <= 1'b1; // see [RULE_02]
          trunc_done_r <= 1'b1;
        end
      end
    end
  end

  // Frame is cut off from the truncation point until it ends
  assign rx_drop_frame = trunc_done_r && rx_frame_active; // see [RULE_02]

  // ----------------------------------------
  // Fault and lane status
  // ----------------------------------------
  logic lf_fault;
  logic aligned_nxt;

  rsm_lf_sm u_lf_sm (
    .mclk(mclk),
    .rst_b(rst_b),
    .word_vld(rx_word_vld),
    .lf_word(rx_lf_word && process_local_fault), // see [RULE_11]
    .fault(lf_fault)
  );

  assign aligned_nxt = &lane_deskewed; // see [RULE_15]

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lanes_aligned <= 1'b0;
      high_error_rate <= 1'b0;
      internal_local_fault <= 1'b0;
      received_local_fault <= 1'b0;
    end else begin
      lanes_aligned <= aligned_nxt;
      high_error_rate <= ber_over_threshold; // see [RULE_06]
      internal_local_fault <= tx_test_pattern || !aligned_nxt || ber_over_threshold; // see [RULE_03]
      received_local_fault <= lf_fault && process_local_fault; // see [RULE_04]
    end
  end

  // ----------------------------------------
  // Per-lane and ordered-set events
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < VL_LANES; gi++) begin : g_bip
      always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
          bip_err[gi] <= 1'b0;
        end else begin
          bip_err[gi] <= lane_bip_bad[gi]; // see [RULE_05]
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      signal_set_seen <= 1'b0;
    end else begin
      signal_set_seen <= rx_word_vld && rx_signal_os_word; // see [RULE_10]
    end
  end

  // ----------------------------------------
  // Preamble capture
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      preamble_out <= `RSM_PRE_RST;
    end else if (rx_sof && custom_preamble_enable) begin
      preamble_out <= rx_preamble; // see [RULE_07]
    end
  end

  // ----------------------------------------
  // Test pattern
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      test_pattern_mismatch <= '0;
      rx_check_idle <= 1'b0;
      tx_scrambled_idle <= 1'b0;
    end else begin
      rx_check_idle <= rx_test_pattern; // see [RULE_12]
      tx_scrambled_idle <= tx_test_pattern; // see [RULE_13]
      test_pattern_mismatch <= rx_test_pattern ? rx_pattern_errs : '0; // see [RULE_14] [RULE_16]
    end
  end

  // ----------------------------------------
  // Inter-packet gap
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_send_idles <= 1'b1;
      tx_gap_bytes <= `RSM_IPG_TYPICAL;
    end else if (tx_ipg_value <= `RSM_IPG_MIN_LIMIT) begin
      tx_send_idles <= 1'b0; // see [RULE_09]
      tx_gap_bytes <= `RSM_IPG_TERM_BYTES;
    end else begin
      tx_send_idles <= 1'b1; // see [RULE_08]
      tx_gap_bytes <= tx_ipg_value;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_overflow;
    rx_frame_active && rx_byte_inc_vld && !trunc_done_r && len_sum > {1'b0, max_frame_len};
  endsequence

  AST_STOMP: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_01]
    stomped_fcs == $past(rx_frame_end && rx_fcs_inverted)) else $error("stomp pulse wrong");
  AST_TRUNC: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_02]
    s_overflow |=> truncated ##1 !truncated) else $error("truncation pulse wrong");
  AST_ILF: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_03]
    !(&lane_deskewed) |=> internal_local_fault) else $error("internal fault missing");
  AST_RLF: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_04]
    !process_local_fault |=> !received_local_fault) else $error("fault not ignored");
  AST_BIP: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_05]
    bip_err == $past(lane_bip_bad)) else $error("bip pulse wrong");
  AST_HBER: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_06]
    $rose(ber_over_threshold) |=> high_error_rate && internal_local_fault)
    else $error("ber level wrong");
  AST_PRE: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_07]
    rx_sof && custom_preamble_enable |=> preamble_out == $past(rx_preamble))
    else $error("preamble not captured");
  AST_GAP: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_09]
    tx_ipg_value < 4'h8 |=> !tx_send_idles) else $error("idles in minimal gap");
  AST_SOS: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_10]
    rx_word_vld && rx_signal_os_word |=> signal_set_seen) else $error("signal set missed");
  AST_MISM: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_16]
    !rx_test_pattern |=> test_pattern_mismatch == '0) else $error("mismatch while off");
  AST_ALIGN: assert property (@(posedge mclk) disable iff (!rst_b) // see [RULE_15]
    $past(rst_b) |-> lanes_aligned == $past(&lane_deskewed))
    else $error("aligned status wrong");
endmodule : rsm_top

// ==== inc/rsm_cfg.svh ====
`ifndef RSM_CFG_SVH
`define RSM_CFG_SVH

// Lane and width figures
`define RSM_VL_LANES 4
`define RSM_MAX_LEN_W 15
`define RSM_PRE_W 56
`define RSM_IPG_W 4
`define RSM_MISM_W 3
// Gap settings up to this value mean minimal gap
`define RSM_IPG_MIN_LIMIT 4'h7
`define RSM_IPG_TYPICAL 4'hC
// Terminate word alone gives about this many gap bytes
`define RSM_IPG_TERM_BYTES 4'h4
// Consecutive fault sequences needed to trip the fault machine
`define RSM_LF_TRIP 2'h3
// One less than the fault-free cycles needed to clear the fault machine
`define RSM_LF_CLEAR_CYC 7'h7F
// Preamble bytes reset value
`define RSM_PRE_RST 56'h0

`endif

// ==== inc/rsm_pkg.sv ====
package rsm_pkg;
  typedef enum logic [1:0] {
    RSM_LF_OK,
    RSM_LF_COUNT,
    RSM_LF_FAULT
  } rsm_lf_st_t;

  typedef enum logic [1:0] {
    RSM_GAP_MINIMAL,
    RSM_GAP_IDLES
  } rsm_gap_mode_t;
endpackage : rsm_pkg

// ==== rtl/rsm_lf_sm.sv ====
`timescale 1ns/1ps
`include "rsm_cfg.svh"

// Local fault sequence state machine: trips after a run of fault words,
// clears after a long run without any.
module rsm_lf_sm (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Incoming word qualifiers
  input wire logic word_vld,
  input wire logic lf_word,
  // Status
  output logic fault
);
  rsm_pkg::rsm_lf_st_t st_r;
  logic [1:0] hit_r;
  logic [6:0] quiet_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= rsm_pkg::RSM_LF_OK;
      hit_r <= 2'h0;
      quiet_r <= 7'h0;
    end else if (word_vld) begin
      unique case (st_r)
        rsm_pkg::RSM_LF_OK: begin
          if (lf_word) begin
            st_r <= rsm_pkg::RSM_LF_COUNT;
            hit_r <= 2'h1;
          end
        end
        rsm_pkg::RSM_LF_COUNT: begin
          if (!lf_word) begin
            st_r <= rsm_pkg::RSM_LF_OK;
            hit_r <= 2'h0;
          end else if (hit_r + 2'h1 >= `RSM_LF_TRIP) begin
            st_r <= rsm_pkg::RSM_LF_FAULT;
            quiet_r <= 7'h0;
          end else begin
            hit_r <= hit_r + 2'h1;
          end
        end
        rsm_pkg::RSM_LF_FAULT: begin
          if (lf_word) begin
            quiet_r <= 7'h0;
          end else if (quiet_r == `RSM_LF_CLEAR_CYC) begin
            st_r <= rsm_pkg::RSM_LF_OK;
            hit_r <= 2'h0;
          end else begin
            quiet_r <= quiet_r + 7'h1;
          end
        end
      endcase
    end
  end

  assign fault = (st_r == rsm_pkg::RSM_LF_FAULT);
endmodule : rsm_lf_sm

// ==== dv/rsm_link_partner.sv ====
`timescale 1ns/1ps

// Far end of the lanes: one word each cycle, fault or Signal words on request
module rsm_link_partner (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Requests from the bench
  input wire logic lf_req,
  input wire logic sos_req,
  // Decoded word qualifiers
  output logic word_vld,
  output logic lf_word,
  output logic signal_os_word
);
  always @(negedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      word_vld <= 1'b0;
      lf_word <= 1'b0;
      signal_os_word <= 1'b0;
    end else begin
      word_vld <= 1'b1;
      lf_word <= lf_req;
      signal_os_word <= sos_req;
    end
  end
endmodule : rsm_link_partner

// ==== dv/rsm_top_tb.sv ====
`timescale 1ns/1ps
`include "rsm_cfg.svh"
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module rsm_top_tb;
  logic mclk, rst_b, fe, finv, fact, bvld, sof, sos_req, lf_req, ber, cpe, plf, rtp, ttp;
  logic wvld, lfw, sosw, stomp, trunc, drop, ilf, rlf, her, aln, sss, sidl, tscr, rchk;
  logic [4:0] binc;
  logic [55:0] pre, pout;
  logic [3:0] bip, desk, ipg, berr, gap;
  logic [2:0] perr, mism;
  logic [14:0] maxlen;
  int err_total, checked, n, pulses;

  rsm_link_partner u_lp (.mclk(mclk), .rst_b(rst_b), .lf_req(lf_req), .sos_req(sos_req),
    .word_vld(wvld), .lf_word(lfw), .signal_os_word(sosw));

  rsm_top u_dut (.mclk(mclk), .rst_b(rst_b), .rx_frame_end(fe), .rx_fcs_inverted(finv),
    .rx_frame_active(fact), .rx_byte_inc_vld(bvld), .rx_byte_inc(binc), .rx_sof(sof),
    .rx_preamble(pre), .rx_word_vld(wvld), .rx_lf_word(lfw), .rx_signal_os_word(sosw),
    .lane_bip_bad(bip), .lane_deskewed(desk), .ber_over_threshold(ber),
    .rx_pattern_errs(perr), .max_frame_len(maxlen), .custom_preamble_enable(cpe),
    .process_local_fault(plf), .rx_test_pattern(rtp), .tx_test_pattern(ttp),
    .tx_ipg_value(ipg), .stomped_fcs(stomp), .truncated(trunc), .rx_drop_frame(drop),
    .internal_local_fault(ilf), .received_local_fault(rlf), .bip_err(berr),
    .high_error_rate(her), .lanes_aligned(aln), .signal_set_seen(sss),
    .preamble_out(pout), .test_pattern_mismatch(mism), .tx_send_idles(sidl),
    .tx_gap_bytes(gap), .tx_scrambled_idle(tscr), .rx_check_idle(rchk));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #200000;
    err_total++;
    conclude();
  end

  task automatic conclude();
    $display("Counts: checked=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // One frame of n eight-byte beats; counts truncation pulses
  task automatic frame(input int beats, input int exp_n);
    pulses = 0;
    fact = 1'b1;
    for (int k = 0; k < beats + 3; k++) begin
      bvld = (k < beats);
      binc = 5'h08;
      @(negedge mclk);
      pulses += int'(trunc !== 1'b0);
    end
    `CHK(drop, exp_n == 1)
    fact = 1'b0;
    @(negedge mclk);
    `CHK(pulses, exp_n)
    `CHK(drop, 1'b0)
  endtask : frame

  // Bounded wait for a level on the received fault
  task automatic wait_rlf(input logic v, input int lim);
    n = 0;
    while (rlf !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
    `CHK(rlf, v)
    if (rlf !== v) conclude();
  endtask : wait_rlf

  initial begin
    {fe, finv, fact, bvld, sof, sos_req, lf_req, ber, cpe, plf, rtp, ttp} = '0;
    binc = 5'h00;
    pre = 56'h0;
    bip = 4'h0;
    desk = 4'hF;
    ipg = `RSM_IPG_TYPICAL;
    perr = 3'h0;
    maxlen = 15'h0010;
    err_total = 0;
    checked = 0;
    rst_b = 1'b0;
    repeat (12) @(negedge mclk);
    `CHK(sidl, 1'b1)
    `CHK(gap, `RSM_IPG_TYPICAL)
    rst_b = 1'b1;
    // Back-to-back pulses
    fe = 1'b1;
    finv = 1'b1;
    bip = 4'hA;
    @(negedge mclk);
    `CHK(stomp, 1'b1)
    `CHK(berr, 4'hA)
    bip = 4'h5;
    @(negedge mclk);
    `CHK(stomp, 1'b1)
    `CHK(berr, 4'h5)
    finv = 1'b0;
    bip = 4'h0;
    @(negedge mclk);
    `CHK(stomp, 1'b0)
    `CHK(berr, 4'h0)
    fe = 1'b0;
    $display("Test pulses finished");
    for (int v = 0; v < 16; v++) begin
      ipg = v[3:0];
      @(negedge mclk);
      `CHK(sidl, v > 7)
      `CHK(gap, (v > 7) ? v[3:0] : `RSM_IPG_TERM_BYTES)
    end
    $display("Test gap finished");
    for (int i = 0; i < 4; i++) begin
      ttp = (i == 0);
      desk = (i == 1) ? 4'h7 : 4'hF;
      ber = (i == 2);
      repeat (2) @(negedge mclk);
      `CHK(ilf, i < 3)
      `CHK(aln, i != 1)
      `CHK(her, i == 2)
      `CHK(tscr, i == 0)
    end
    $display("Test faults finished");
    rtp = 1'b1;
    perr = 3'h5;
    @(negedge mclk);
    `CHK(mism, 3'h5)
    `CHK(rchk, 1'b1)
    rtp = 1'b0;
    @(negedge mclk);
    `CHK(mism, 3'h0)
    `CHK(rchk, 1'b0)
    perr = 3'h0;
    cpe = 1'b1;
    pre = 56'h11223344556677;
    sof = 1'b1;
    @(negedge mclk);
    sof = 1'b0;
    pre = 56'h0;
    @(negedge mclk);
    `CHK(pout, 56'h11223344556677)
    // A frame start with reporting off must leave the last preamble
    cpe = 1'b0;
    pre = 56'hA5A5A5A5A5A5A5;
    sof = 1'b1;
    @(negedge mclk);
    sof = 1'b0;
    @(negedge mclk);
    `CHK(pout, 56'h11223344556677)
    $display("Test pattern and preamble finished");
    frame(2, 0);
    frame(3, 1);
    $display("Test truncation finished");
    lf_req <= 1'b1;
    repeat (8) @(negedge mclk);
    `CHK(rlf, 1'b0)
    plf = 1'b1;
    wait_rlf(1'b1, 10);
    lf_req <= 1'b0;
    wait_rlf(1'b0, 200);
    sos_req <= 1'b1;
    @(negedge mclk);
    sos_req <= 1'b0;
    n = 0;
    while (sss !== 1'b1 && n < 5) begin
      @(negedge mclk);
      n++;
    end
    `CHK(sss, 1'b1)
    @(negedge mclk);
    `CHK(sss, 1'b0)
    $display("Test link words finished");
    conclude();
  end
endmodule : rsm_top_tb
